/* verilog/tsic_map.vh */
// Register indices, bit positions and reset values of the timer status block
`ifndef TSIC_MAP_VH
`define TSIC_MAP_VH

// Register indices; byte address on the bus is four times the index
`define TSIC_IDX_CAP1H    6'h20
`define TSIC_IDX_CAP1L    6'h21
`define TSIC_IDX_CMP1H    6'h22
`define TSIC_IDX_CMP1L    6'h23
`define TSIC_IDX_CAP2H    6'h24
`define TSIC_IDX_CAP2L    6'h25
`define TSIC_IDX_CMP2H    6'h26
`define TSIC_IDX_CMP2L    6'h27
`define TSIC_IDX_CNTH     6'h28
`define TSIC_IDX_CNTL     6'h29
`define TSIC_IDX_ACNTH    6'h2A
`define TSIC_IDX_ACNTL    6'h2B
`define TSIC_IDX_CTRL1    6'h2C
`define TSIC_IDX_CTRL2    6'h2D
`define TSIC_IDX_FLAGS    6'h2E

// Status register bit positions
`define TSIC_ST_CAP1F     7
`define TSIC_ST_CAP2F     6
`define TSIC_ST_CMP1F     5
`define TSIC_ST_OVF       4
`define TSIC_ST_PIN1      3
`define TSIC_ST_PIN2      2
`define TSIC_ST_CMP2F     1

// Control register 1 bit positions
`define TSIC_C1_CAP1IE    7
`define TSIC_C1_CAP2IE    6
`define TSIC_C1_CMP1IE    5
`define TSIC_C1_OVFIE     4
`define TSIC_C1_EDGE1     2
`define TSIC_C1_EDGE2     1
// Control register 2 bit position and writable masks
`define TSIC_C2_CMP2IE    5
`define TSIC_C1_MASK      8'hFF
`define TSIC_C2_MASK      8'h29

// Reset values
`define TSIC_CTRL1_RST    8'h00
`define TSIC_CTRL2_RST    8'h00
`define TSIC_CNT_RST      16'hFFFC
`define TSIC_CNT_MAX      16'hFFFF

// Prescaler: counter steps once every four bus clocks
`define TSIC_PRESC_LAST   2'h3

`endif

/* verilog/tsic_top.v */
// Timer status flags, dual input capture and free-running counter
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tsic_map.vh"

module tsic_top (
    input  wire        i_core_clk,
    input  wire        i_rst_n,
    // AHB-Lite slave
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output reg  [31:0] o_hrdata,
    output reg         o_hreadyout,
    output reg         o_hresp,
    // Capture pins and stop mode request (asynchronous)
    input  wire        i_capture_pin_one,
    input  wire        i_capture_pin_two,
    input  wire        i_stop_mode,
    // Timer interrupt request
    output reg         o_timer_irq
);

    // Flag vector order
    localparam F_CAP1 = 0;
    localparam F_CAP2 = 1;
    localparam F_CMP1 = 2;
    localparam F_CMP2 = 3;
    localparam F_OVF  = 4;

    // Bus decode state
    reg         wr_pend_q;
    reg  [5:0]  wr_idx_q;
    // Control registers
    reg  [7:0]  ctrl1_q;
    reg  [7:0]  ctrl2_q;
    // Compare registers and their inhibit
    reg  [15:0] cmp1_q;
    reg  [15:0] cmp2_q;
    reg         cmp1_inh_q;
    reg         cmp2_inh_q;
    // Counter, prescaler and history for capture alignment
    reg  [1:0]  presc_q;
    reg  [15:0] cnt_q;
    reg  [15:0] hist1_q;
    reg  [15:0] hist2_q;
    reg  [15:0] hist3_q;
    reg         cmp_tick_q;
    reg  [7:0]  cnt_buf_q;
    reg         cnt_lat_q;
    // Flags and clear arming
    reg  [4:0]  flag_q;
    reg  [4:0]  flag_d;
    reg  [4:0]  arm_q;
    reg  [4:0]  arm_d;
    // Stop mode synchroniser
    reg         stop_s1_q;
    reg         stop_q;
    // Read data mux
    reg  [7:0]  rd_byte;

    // Address phase decode
    wire        ap_ok   = i_hsel & i_htrans[1] & i_hready;
    wire        in_map  = (i_haddr[31:8] == 24'h000000) &
                          (i_haddr[1:0] == 2'h0);
    wire        rd_en   = ap_ok & ~i_hwrite & in_map;
    wire        wr_en   = ap_ok & i_hwrite & in_map;
    wire [5:0]  ap_idx  = i_haddr[7:2];
    wire [7:0]  wbyte   = i_hwdata[7:0];

    // Per-register access strobes
    wire rd_flags = rd_en & (ap_idx == `TSIC_IDX_FLAGS);
    wire wr_flags = wr_pend_q & (wr_idx_q == `TSIC_IDX_FLAGS);
    wire rd_cap1h = rd_en & (ap_idx == `TSIC_IDX_CAP1H);
    wire rd_cap1l = rd_en & (ap_idx == `TSIC_IDX_CAP1L);
    wire rd_cap2h = rd_en & (ap_idx == `TSIC_IDX_CAP2H);
    wire rd_cap2l = rd_en & (ap_idx == `TSIC_IDX_CAP2L);
    wire wr_cmp1h = wr_pend_q & (wr_idx_q == `TSIC_IDX_CMP1H);
    wire wr_cmp1l = wr_pend_q & (wr_idx_q == `TSIC_IDX_CMP1L);
    wire wr_cmp2h = wr_pend_q & (wr_idx_q == `TSIC_IDX_CMP2H);
    wire wr_cmp2l = wr_pend_q & (wr_idx_q == `TSIC_IDX_CMP2L);
    wire acc_cmp1l = wr_cmp1l | (rd_en & (ap_idx == `TSIC_IDX_CMP1L));
    wire acc_cmp2l = wr_cmp2l | (rd_en & (ap_idx == `TSIC_IDX_CMP2L));
    wire rd_cnth  = rd_en & ((ap_idx == `TSIC_IDX_CNTH) |
                             (ap_idx == `TSIC_IDX_ACNTH));
    wire rd_cntl  = rd_en & (ap_idx == `TSIC_IDX_CNTL);
    wire rd_acntl = rd_en & (ap_idx == `TSIC_IDX_ACNTL);

    // Control fields
    wire [1:0] edge_sel = {ctrl1_q[`TSIC_C1_EDGE2], ctrl1_q[`TSIC_C1_EDGE1]};
    wire [4:0] irq_en   = {ctrl1_q[`TSIC_C1_OVFIE],
                           ctrl2_q[`TSIC_C2_CMP2IE],
                           ctrl1_q[`TSIC_C1_CMP1IE],
                           ctrl1_q[`TSIC_C1_CAP2IE],
                           ctrl1_q[`TSIC_C1_CAP1IE]};

    // Counter step strobe, frozen in stop mode
    wire        tick    = (presc_q == `TSIC_PRESC_LAST) & ~stop_q;
    wire        ovf_evt = tick & (cnt_q == `TSIC_CNT_MAX);
    wire [15:0] cap_val = hist3_q + 16'h0001;

    // Per-channel capture wiring
    wire [1:0]  pins    = {i_capture_pin_two, i_capture_pin_one};
    wire [1:0]  rd_hi   = {rd_cap2h, rd_cap1h};
    wire [1:0]  rd_lo   = {rd_cap2l, rd_cap1l};
    wire [1:0]  cap_evt;
    wire [1:0]  pin_lvl;
    wire [31:0] cap_flat;

    // Stop mode input synchroniser
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            stop_s1_q <= 1'b0;
            stop_q    <= 1'b0;
        end
        else
        begin
            stop_s1_q <= i_stop_mode;
            stop_q    <= stop_s1_q;
        end
    end

    // Capture channels: sync, edge detect, inhibit, stop arming
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : gen_cap
            reg        s1_q;
            reg        s2_q;
            reg        s3_q;
            reg        inh_q;
            reg        armed_q;
            reg [15:0] pend_q;
            reg [15:0] cap_q;
            wire       rise = s2_q & ~s3_q;
            wire       fall = ~s2_q & s3_q;
            wire       hit  = edge_sel[g] ? rise : fall;
            wire       wake = ~stop_q & armed_q;
            wire       live = ~stop_q & hit;

            // Pin synchroniser and previous level
            always @(posedge i_core_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end
                else
                begin
                    s1_q <= pins[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            // High read blocks, low read releases
            always @(posedge i_core_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    inh_q <= 1'b0;
                else if (rd_hi[g])
                    inh_q <= 1'b1;
                else if (rd_lo[g])
                    inh_q <= 1'b0;
            end

            // Stop-mode edge arms; reset discards the armed edge
            always @(posedge i_core_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    armed_q <= 1'b0;
                else if (stop_q & hit & ~armed_q)
                    armed_q <= 1'b1;
                else if (wake)
                    armed_q <= 1'b0;
            end

            // Value held for the armed edge
            always @(posedge i_core_clk)
            begin
                if (stop_q & hit & ~armed_q)
                    pend_q <= cap_val;
            end

            // Capture register; no reset so contents survive reset
            always @(posedge i_core_clk)
            begin
                if (wake & ~inh_q)
                    cap_q <= pend_q;
                else if (live & ~inh_q)
                    cap_q <= cap_val;
            end

            assign cap_evt[g] = live | wake;
            assign pin_lvl[g] = s2_q;
            assign cap_flat[16*g+15:16*g] = cap_q;
        end
    endgenerate

    // Prescaler, counter and its delay history
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            presc_q    <= 2'h0;
            cnt_q      <= `TSIC_CNT_RST;
            hist1_q    <= `TSIC_CNT_RST;
            hist2_q    <= `TSIC_CNT_RST;
            hist3_q    <= `TSIC_CNT_RST;
            cmp_tick_q <= 1'b0;
        end
        else
        begin
            if (!stop_q)
                presc_q <= presc_q + 2'h1;
            if (tick)
                cnt_q <= cnt_q + 16'h0001;
            hist1_q    <= cnt_q;
            hist2_q    <= hist1_q;
            hist3_q    <= hist2_q;
            cmp_tick_q <= tick;
        end
    end

    // Counter low byte buffer for coherent two-byte reads
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_buf_q <= 8'h00;
            cnt_lat_q <= 1'b0;
        end
        else if (rd_cnth)
        begin
            if (!cnt_lat_q)
                cnt_buf_q <= cnt_q[7:0];
            cnt_lat_q <= 1'b1;
        end
        else if (rd_cntl | rd_acntl)
            cnt_lat_q <= 1'b0;
    end

    // Control registers
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl1_q <= `TSIC_CTRL1_RST;
            ctrl2_q <= `TSIC_CTRL2_RST;
        end
        else if (wr_pend_q)
        begin
            if (wr_idx_q == `TSIC_IDX_CTRL1)
                ctrl1_q <= wbyte & `TSIC_C1_MASK;
            if (wr_idx_q == `TSIC_IDX_CTRL2)
                ctrl2_q <= wbyte & `TSIC_C2_MASK;
        end
    end

    // Compare registers: contents not reset
    always @(posedge i_core_clk)
    begin
        if (wr_cmp1h)
            cmp1_q[15:8] <= wbyte;
        if (wr_cmp1l)
            cmp1_q[7:0] <= wbyte;
        if (wr_cmp2h)
            cmp2_q[15:8] <= wbyte;
        if (wr_cmp2l)
            cmp2_q[7:0] <= wbyte;
    end

    // Compare inhibit between high and low byte writes
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cmp1_inh_q <= 1'b0;
            cmp2_inh_q <= 1'b0;
        end
        else
        begin
            if (wr_cmp1h)
                cmp1_inh_q <= 1'b1;
            else if (wr_cmp1l)
                cmp1_inh_q <= 1'b0;
            if (wr_cmp2h)
                cmp2_inh_q <= 1'b1;
            else if (wr_cmp2l)
                cmp2_inh_q <= 1'b0;
        end
    end

    // Compare match one cycle after each counter step
    wire cmp1_evt = cmp_tick_q & ~cmp1_inh_q & (cnt_q == cmp1_q);
    wire cmp2_evt = cmp_tick_q & ~cmp2_inh_q & (cnt_q == cmp2_q);

    // Flag set and two-step clear; a set wins over a clear
    always @*
    begin
        flag_d = flag_q;
        arm_d  = arm_q;
        // Step one: status read arms every flag now set; a status write arms only the compare and overflow flags
        if (rd_flags)
            arm_d[F_CAP2:F_CAP1] = arm_q[F_CAP2:F_CAP1] |
                                   flag_q[F_CAP2:F_CAP1];
        if (rd_flags | wr_flags)
            arm_d[F_OVF:F_CMP1] = arm_q[F_OVF:F_CMP1] |
                                  flag_q[F_OVF:F_CMP1];
        // Step two: access to the flag's own register
        if (arm_q[F_CAP1] & rd_cap1l)
        begin
            flag_d[F_CAP1] = 1'b0;
            arm_d[F_CAP1]  = 1'b0;
        end
        if (arm_q[F_CAP2] & rd_cap2l)
        begin
            flag_d[F_CAP2] = 1'b0;
            arm_d[F_CAP2]  = 1'b0;
        end
        if (arm_q[F_CMP1] & acc_cmp1l)
        begin
            flag_d[F_CMP1] = 1'b0;
            arm_d[F_CMP1]  = 1'b0;
        end
        if (arm_q[F_CMP2] & acc_cmp2l)
        begin
            flag_d[F_CMP2] = 1'b0;
            arm_d[F_CMP2]  = 1'b0;
        end
        if (arm_q[F_OVF] & rd_cntl)
        begin
            flag_d[F_OVF] = 1'b0;
            arm_d[F_OVF]  = 1'b0;
        end
        // Hardware events last so they win
        if (cap_evt[0])
            flag_d[F_CAP1] = 1'b1;
        if (cap_evt[1])
            flag_d[F_CAP2] = 1'b1;
        if (cmp1_evt)
            flag_d[F_CMP1] = 1'b1;
        if (cmp2_evt)
            flag_d[F_CMP2] = 1'b1;
        if (ovf_evt)
            flag_d[F_OVF] = 1'b1;
    end

    // Flag and arm registers
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            flag_q <= 5'h00;
            arm_q  <= 5'h00;
        end
        else
        begin
            flag_q <= flag_d;
            arm_q  <= arm_d;
        end
    end

    // Read data selection
    always @*
    begin
        rd_byte = 8'h00;
        case (ap_idx)
            `TSIC_IDX_CAP1H: rd_byte = cap_flat[15:8];
            `TSIC_IDX_CAP1L: rd_byte = cap_flat[7:0];
            `TSIC_IDX_CAP2H: rd_byte = cap_flat[31:24];
            `TSIC_IDX_CAP2L: rd_byte = cap_flat[23:16];
            `TSIC_IDX_CMP1H: rd_byte = cmp1_q[15:8];
            `TSIC_IDX_CMP1L: rd_byte = cmp1_q[7:0];
            `TSIC_IDX_CMP2H: rd_byte = cmp2_q[15:8];
            `TSIC_IDX_CMP2L: rd_byte = cmp2_q[7:0];
            `TSIC_IDX_CNTH,
            `TSIC_IDX_ACNTH: rd_byte = cnt_q[15:8];
            `TSIC_IDX_CNTL,
            `TSIC_IDX_ACNTL: rd_byte = cnt_lat_q ? cnt_buf_q : cnt_q[7:0];
            `TSIC_IDX_CTRL1: rd_byte = ctrl1_q;
            `TSIC_IDX_CTRL2: rd_byte = ctrl2_q;
            `TSIC_IDX_FLAGS:
            begin
                rd_byte[`TSIC_ST_CAP1F] = flag_q[F_CAP1];
                rd_byte[`TSIC_ST_CAP2F] = flag_q[F_CAP2];
                rd_byte[`TSIC_ST_CMP1F] = flag_q[F_CMP1];
                rd_byte[`TSIC_ST_OVF]   = flag_q[F_OVF];
                rd_byte[`TSIC_ST_PIN1]  = pin_lvl[0];
                rd_byte[`TSIC_ST_PIN2]  = pin_lvl[1];
                rd_byte[`TSIC_ST_CMP2F] = flag_q[F_CMP2];  // bit 0 stays 0
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // AHB-Lite slave: zero wait states, always OKAY
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_pend_q   <= 1'b0;
            wr_idx_q    <= 6'h00;
            o_hrdata    <= 32'h00000000;
            o_hreadyout <= 1'b0;
            o_hresp     <= 1'b0;
        end
        else
        begin
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            wr_pend_q   <= wr_en;    // status write only arms, never sets
            wr_idx_q    <= ap_idx;
            if (rd_en)
                o_hrdata <= {24'h000000, rd_byte};
            else if (ap_ok)
                o_hrdata <= 32'h00000000;
        end
    end

    // Interrupt request from enabled flags
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_timer_irq <= 1'b0;
        else
            o_timer_irq <= |(flag_q & irq_en);
    end

endmodule // tsic_top

/* verification/tsic_monitor.sv */
// Port checks of the timer status and capture block
`timescale 1ns/1ps
`include "tsic_map.vh"
module tsic_monitor (
    input wire        i_core_clk,
    input wire        i_rst_n,
    input wire        i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0]  i_htrans,
    input wire        i_hwrite,
    input wire [2:0]  i_hsize,
    input wire [31:0] i_hwdata,
    input wire        i_hready,
    input wire [31:0] o_hrdata,
    input wire        o_hreadyout,
    input wire        o_hresp,
    input wire        i_capture_pin_one,
    input wire        i_capture_pin_two,
    input wire        i_stop_mode,
    input wire        o_timer_irq
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Accepted transfers and decoded places
    wire       acc = i_hsel && i_htrans[1] && i_hready;
    wire       rd = acc && !i_hwrite;
    wire       rd_st = rd && i_haddr[7:2] == `TSIC_IDX_FLAGS;
    wire       rd_alt = rd && i_haddr[7:2] == `TSIC_IDX_ACNTL;
    wire       wr_ctl = acc && i_hwrite && i_haddr[7:3] == 5'h16;
    wire [1:0] pins = {i_capture_pin_one, i_capture_pin_two};
    reg        en_q;

    // Any control write since reset
    always @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            en_q <= 1'b0;
        else if (wr_ctl)
            en_q <= 1'b1;
    end

    property p_okay;
        o_hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay)
        else $error("response not OKAY");

    property p_ready;
        $past(i_rst_n) |-> o_hreadyout;
    endproperty
    a_ready: assert property (p_ready)
        else $error("wait state seen");

    property p_bit0;
        rd_st |=> o_hrdata[0] == 1'b0;
    endproperty
    a_bit0: assert property (p_bit0)
        else $error("status bit 0 set");

    property p_pins;
        rd_st && $past(i_rst_n, 3) && $stable(pins) && $past(pins, 2) == pins
            |=> o_hrdata[3:2] == $past(pins);
    endproperty
    a_pins: assert property (p_pins)
        else $error("pin level bits wrong");

    property p_hi0;
        rd |=> o_hrdata[31:8] == 24'h000000;
    endproperty
    a_hi0: assert property (p_hi0)
        else $error("upper read bits set");

    property p_unmap;
        rd && i_haddr[7:6] == 2'b01 |=> o_hrdata == 32'h00000000;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");

    property p_step;
        rd_alt ##4 rd_alt |=> o_hrdata[7:0] == $past(o_hrdata[7:0], 4) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("count step wrong");

    property p_irq;
        !en_q |-> !o_timer_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt without enable");

    property p_hold;
        !acc |=> $stable(o_hrdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read data moved");
endmodule // tsic_monitor

bind tsic_top tsic_monitor u_mon (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
    .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_capture_pin_one(i_capture_pin_one),
    .i_capture_pin_two(i_capture_pin_two),
    .i_stop_mode(i_stop_mode), .o_timer_irq(o_timer_irq)
);

/* verification/tsic_pin_src.sv */
// External sources driving the two capture pins
`timescale 1ns/1ps
module tsic_pin_src (
    input  wire [1:0] i_lvl,
    output reg        o_pin_one,
    output reg        o_pin_two
);
    // Pins move well clear of the bus clock edge
    initial {o_pin_one, o_pin_two} = 2'b00;
    always @(i_lvl)
        {o_pin_one, o_pin_two} <= #30 i_lvl;
endmodule // tsic_pin_src

/* verification/tsic_top_tb.sv */
// Self-checking bench for the timer status and capture block
`timescale 1ns/1ps
`include "tsic_map.vh"
module tsic_top_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  lvl = 2'h0;
    logic        stop = 1'b0;
    logic [15:0] ref_q, ca, c1, c2;
    logic [1:0]  pre_q;
    logic [7:0]  d;
    logic [5:0]  hi;
    wire  [31:0] hrdata;
    wire         hready, hresp, irq, pin1, pin2;
    int          error_cnt = 0;
    int          n_tests = 0;

    // Bus clock, 100 ns period
    always #50 clk = ~clk;

    // Reference count, one step every fourth clock
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_q <= `TSIC_CNT_RST;
            pre_q <= 2'h0;
        end
        else
        begin
            pre_q <= pre_q + 2'h1;
            ref_q <= ref_q + {15'h0, pre_q == `TSIC_PRESC_LAST};
        end
    end

    tsic_pin_src u_src (.i_lvl(lvl), .o_pin_one(pin1), .o_pin_two(pin2));

    tsic_top u_dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_capture_pin_one(pin1), .i_capture_pin_two(pin2),
        .i_stop_mode(stop), .o_timer_irq(irq)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task automatic wait_rdy;
        int n;
    begin
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1)
        begin
            error_cnt++;
            $display("[ERR] %0t bus timeout", $time);
            print_verdict;
        end
    end
    endtask

    // One single transfer; read byte lands in d
    task automatic xfer(input logic [5:0] idx, input logic wr,
                        input logic [7:0] wd);
    begin
        haddr  <= {24'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy;
        ca = ref_q;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_rdy;
        d = hrdata[7:0];
    end
    endtask

    task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
    begin
        xfer(idx, 1'b0, 8'h00);
        chk(d, e);
    end
    endtask

    task automatic cap_chk(input logic [5:0] h, input logic [15:0] e);
    begin
        rchk(h, e[15:8]);
        rchk(h + 6'h1, e[7:0]);
    end
    endtask

    // Pin moves just after a step, so the expected count is unambiguous
    task automatic pin_to(input int k, input logic v, output logic [15:0] e);
        int n;
    begin
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (pre_q !== 2'h0 && n < 8);
        if (pre_q !== 2'h0)
        begin
            error_cnt++;
            $display("[ERR] %0t prescaler phase timeout", $time);
            print_verdict;
        end
        lvl[k] <= v;
        e = ref_q + 16'h1;
        repeat (6) @(posedge clk);
    end
    endtask

    task automatic pulse1(output logic [15:0] e);
        logic [15:0] x;
    begin
        pin_to(1, 1'b0, x);
        pin_to(1, 1'b1, e);
    end
    endtask

    task automatic fin(input string s);
        $display("Test %s done", s);
    endtask

    task automatic print_verdict;
    begin
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        // Reset values, compare init, overflow and its clear
        rchk(`TSIC_IDX_CTRL1, `TSIC_CTRL1_RST);
        rchk(`TSIC_IDX_CTRL2, `TSIC_CTRL2_RST);
        xfer(`TSIC_IDX_CMP1H, 1'b1, 8'h7F);
        xfer(`TSIC_IDX_CMP2H, 1'b1, 8'h7F);
        xfer(`TSIC_IDX_FLAGS, 1'b0, 8'h00);
        xfer(`TSIC_IDX_CMP1L, 1'b1, 8'hFF);
        xfer(`TSIC_IDX_CMP2L, 1'b1, 8'hFF);
        rchk(`TSIC_IDX_FLAGS, 8'h10);
        repeat (3) xfer(`TSIC_IDX_ACNTL, 1'b0, 8'h00);
        rchk(`TSIC_IDX_FLAGS, 8'h10);
        xfer(`TSIC_IDX_CNTH, 1'b0, 8'h00);
        c1 = ca;
        chk(d, c1[15:8]);
        rchk(`TSIC_IDX_CNTL, c1[7:0]);
        rchk(`TSIC_IDX_FLAGS, 8'h00);
        // Unmapped place, status write, control access
        xfer(6'h10, 1'b1, 8'hFF);
        rchk(6'h10, 8'h00);
        xfer(`TSIC_IDX_FLAGS, 1'b1, 8'hFF);
        rchk(`TSIC_IDX_FLAGS, 8'h00);
        xfer(`TSIC_IDX_CTRL2, 1'b1, 8'hFF);
        rchk(`TSIC_IDX_CTRL2, `TSIC_C2_MASK);
        xfer(`TSIC_IDX_CTRL1, 1'b1, 8'h24);
        rchk(`TSIC_IDX_CTRL1, 8'h24);
        fin("reset and overflow");
        // Capture one on rising edges only
        pin_to(1, 1'b1, c1);
        rchk(`TSIC_IDX_FLAGS, 8'h88);
        chk({7'h0, irq}, 8'h00);
        cap_chk(`TSIC_IDX_CAP1H, c1);
        rchk(`TSIC_IDX_FLAGS, 8'h08);
        pin_to(1, 1'b0, c2);
        rchk(`TSIC_IDX_FLAGS, 8'h00);
        cap_chk(`TSIC_IDX_CAP1H, c1);
        // Capture two on falling edges only
        pin_to(0, 1'b1, c2);
        rchk(`TSIC_IDX_FLAGS, 8'h04);
        pin_to(0, 1'b0, c2);
        rchk(`TSIC_IDX_FLAGS, 8'h40);
        cap_chk(`TSIC_IDX_CAP2H, c2);
        rchk(`TSIC_IDX_FLAGS, 8'h00);
        fin("capture");
        // Overwrite, high-byte inhibit, low-only read, capture interrupt
        xfer(`TSIC_IDX_CTRL1, 1'b1, 8'hA4);
        pin_to(1, 1'b1, c1);
        pulse1(c1);
        cap_chk(`TSIC_IDX_CAP1H, c1);
        xfer(`TSIC_IDX_CAP1H, 1'b0, 8'h00);
        pulse1(c2);
        rchk(`TSIC_IDX_CAP1L, c1[7:0]);
        pulse1(c2);
        rchk(`TSIC_IDX_CAP1L, c2[7:0]);
        rchk(`TSIC_IDX_FLAGS, 8'h88);
        chk({7'h0, irq}, 8'h01);
        rchk(`TSIC_IDX_CAP1L, c2[7:0]);
        fin("inhibit");
        // Compare match, interrupt, two-step clear
        for (int i = 0; i < 2; i++)
        begin
            hi = i ? `TSIC_IDX_CMP2H : `TSIC_IDX_CMP1H;
            c1 = ref_q + 16'h0010;
            xfer(hi, 1'b1, c1[15:8]);
            xfer(hi + 6'h1, 1'b1, c1[7:0]);
            repeat (80) @(posedge clk);
            rchk(`TSIC_IDX_FLAGS, (8'h20 >> (4 * i)) | 8'h08);
            chk({7'h0, irq}, 8'h01);
            xfer(hi + 6'h1, 1'b1, c1[7:0]);
            repeat (2) @(posedge clk);
            chk({7'h0, irq}, 8'h00);
            rchk(`TSIC_IDX_FLAGS, 8'h08);
        end
        fin("compare");
        // Reset keeps capture contents
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        cap_chk(`TSIC_IDX_CAP1H, c2);
        // Edge while stopped is held until wake
        stop <= 1'b1;
        repeat (4) @(posedge clk);
        pin_to(1, 1'b0, c1);
        xfer(`TSIC_IDX_FLAGS, 1'b0, 8'h00);
        chk(d & 8'h80, 8'h00);
        stop <= 1'b0;
        repeat (6) @(posedge clk);
        xfer(`TSIC_IDX_FLAGS, 1'b0, 8'h00);
        chk(d & 8'h80, 8'h80);
        fin("reset and stop");
        print_verdict;
    end
endmodule // tsic_top_tb
